// [rtl/apcc_cfg.svh]
`ifndef APCC_CFG_SVH
`define APCC_CFG_SVH

// ----------------------------------------------------------------
// register indexes (byte address is four times the index)
// ----------------------------------------------------------------
`define APCC_IDX_PORT_CFG   8'h9f
`define APCC_IDX_CONV_CTRL  8'h1f
`define APCC_IDX_RES_HIGH   8'h1e
`define APCC_IDX_RES_LOW    8'h9e
`define APCC_IDX_PORT_DATA  8'h05
`define APCC_IDX_PIN_DIR    8'h85

// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define APCC_CFG_JUSTIFY_BIT  7
`define APCC_CFG_PCFG_LSB     0
`define APCC_CTRL_CLKSEL_LSB  6
`define APCC_CTRL_CHAN_LSB    3
`define APCC_CTRL_GO_BIT      2
`define APCC_CTRL_ENABLE_BIT  0

// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define APCC_PORT_CFG_RST  8'h00
`define APCC_PIN_DIR_RST   5'h1f

// ----------------------------------------------------------------
// timing
// ----------------------------------------------------------------
`define APCC_CLK_NS         25
`define APCC_TAD_RC_NS      4000
`define APCC_TAD_PER_CONV   12
`define APCC_DIV_OSC2       2
`define APCC_DIV_OSC8       8
`define APCC_DIV_OSC32      32

`endif

// [rtl/apcc_pcfg_dec.sv]
`include "apcc_cfg.svh"

module apcc_pcfg_dec
    import apcc_pkg::*;
(
    // port configuration code
    input  wire logic [3:0]    pcfg,
    // decoded pin roles
    output apcc_pin_cfg_t      pinCfg
);

    // mask bit set: pin is analog input or reference, not digital
    always_comb begin
        pinCfg = '{analogMask: 5'h1f, vrefPosPin: 1'b0,
                   vrefNegPin: 1'b0};
        case (pcfg)
            4'h0, 4'h2, 4'h9: begin
            end
            4'h1, 4'h3, 4'ha: begin
                pinCfg.vrefPosPin = 1'b1;
            end
            4'h4: begin
                pinCfg.analogMask = 5'h0b;
            end
            4'h5: begin
                pinCfg.analogMask = 5'h0b;
                pinCfg.vrefPosPin = 1'b1;
            end
            4'h6, 4'h7: begin
                pinCfg.analogMask = 5'h00;
            end
            4'h8, 4'hb, 4'hc: begin
                pinCfg.vrefPosPin = 1'b1;
                pinCfg.vrefNegPin = 1'b1;
            end
            4'hd: begin
                pinCfg.analogMask = 5'h0f;
                pinCfg.vrefPosPin = 1'b1;
                pinCfg.vrefNegPin = 1'b1;
            end
            4'he: begin
                pinCfg.analogMask = 5'h01;
            end
            4'hf: begin
                pinCfg.analogMask = 5'h0d;
                pinCfg.vrefPosPin = 1'b1;
                pinCfg.vrefNegPin = 1'b1;
            end
            default: begin
            end
        endcase
    end

endmodule

// [rtl/apcc_pkg.sv]
package apcc_pkg;

    // ------------------------------------------------------------
    // pin role decode
    // ------------------------------------------------------------
    typedef struct packed {
        logic [4:0] analogMask;
        logic       vrefPosPin;
        logic       vrefNegPin;
    } apcc_pin_cfg_t;

    typedef enum logic [1:0] {
        APCC_CLK_OSC2,
        APCC_CLK_OSC8,
        APCC_CLK_OSC32,
        APCC_CLK_RC
    } apcc_clk_sel_t;

    typedef enum logic {
        APCC_CONV_IDLE,
        APCC_CONV_RUN
    } apcc_conv_st_t;

    // ------------------------------------------------------------
    // module state records
    // ------------------------------------------------------------
    typedef struct packed {
        logic [7:0] cnt;
        logic       tick;
    } apcc_tad_st_t;

    typedef struct packed {
        logic          ack;
        logic [7:0]    rdata;
        logic          justify;
        logic [3:0]    pcfg;
        apcc_clk_sel_t clkSel;
        logic [2:0]    chan;
        logic          enable;
        apcc_conv_st_t conv;
        logic [3:0]    tadCnt;
        logic [9:0]    sample;
        logic [9:0]    result;
        logic [4:0]    portLatch;
        logic [4:0]    pinDir;
        apcc_pin_cfg_t pinCfg;
    } apcc_top_st_t;

endpackage

// [rtl/apcc_tad_gen.sv]
`include "apcc_cfg.svh"

module apcc_tad_gen
    import apcc_pkg::*;
#(
    parameter int RC_CYCLES =
        (`APCC_TAD_RC_NS + `APCC_CLK_NS - 1) / `APCC_CLK_NS
)(
    // clock and reset
    input  wire logic          clock,
    input  wire logic          rst_n,
    // control
    input  wire apcc_clk_sel_t clkSel,
    input  wire logic          run,
    // one pulse per bit conversion period
    output logic               tadTick
);

    if (RC_CYCLES < 2 || RC_CYCLES > 256) begin : g_chk
        $error("RC_CYCLES must lie in 2..256");
    end

    apcc_tad_st_t q;
    apcc_tad_st_t d;
    logic [7:0]   divLast;

    always_comb begin
        case (clkSel)
            APCC_CLK_OSC2:  divLast = 8'(`APCC_DIV_OSC2 - 1);
            APCC_CLK_OSC8:  divLast = 8'(`APCC_DIV_OSC8 - 1);
            APCC_CLK_OSC32: divLast = 8'(`APCC_DIV_OSC32 - 1);
            default:        divLast = 8'(RC_CYCLES - 1);
        endcase
    end

    always_comb begin
        d      = q;
        d.tick = 1'b0;
        if (!run) begin
            d.cnt = 8'h00;
        end else if (q.cnt == divLast) begin
            d.cnt  = 8'h00;
            d.tick = 1'b1;
        end else begin
            d.cnt = q.cnt + 8'h01;
        end
        if (!rst_n) begin
            d = '0;
        end
    end

    always_ff @(posedge clock) begin
        q <= d;
    end

    assign tadTick = q.tick;

    default clocking cb @(posedge clock); endclocking
    default disable iff (!rst_n);

    AST_TAD_OSC2: assert property (
        tadTick && run && clkSel == APCC_CLK_OSC2 && $stable(clkSel)
        |=> !tadTick ##1 (tadTick || !run || $changed(clkSel)))
        else $error("osc/2 period is not two clocks");
    AST_TAD_OSC8: assert property (
        tadTick && clkSel == APCC_CLK_OSC8 |=> (!tadTick) [*7])
        else $error("osc/8 period shorter than eight clocks");

endmodule

// [rtl/apcc_top.sv]
`include "apcc_cfg.svh"

module apcc_top
    import apcc_pkg::*;
#(
    parameter int TAD_PER_CONV = `APCC_TAD_PER_CONV,
    parameter int RC_CYCLES    =
        (`APCC_TAD_RC_NS + `APCC_CLK_NS - 1) / `APCC_CLK_NS
)(
    // clock and reset
    input  wire logic          clock,
    input  wire logic          rst_n,
    // avalon-mm slave
    input  wire logic [9:0]    address,
    input  wire logic          read,
    input  wire logic          write,
    input  wire logic [31:0]   writedata,
    input  wire logic [3:0]    byteenable,
    output logic      [31:0]   readdata,
    output logic               waitrequest,
    // converter pins
    input  wire logic [4:0]    pinIn,
    input  wire logic [9:0]    sampleCode,
    output logic      [4:0]    portOut,
    output logic      [4:0]    portOe_n,
    output apcc_pin_cfg_t      pinCfg,
    output logic      [2:0]    chanSel,
    output logic               converting
);

    if (TAD_PER_CONV < 12 || TAD_PER_CONV > 16) begin : g_chk
        $error("TAD_PER_CONV must lie in 12..16");
    end

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    apcc_top_st_t  q;
    apcc_top_st_t  d;
    apcc_pin_cfg_t pinDec;
    logic          tadTick;

    apcc_pcfg_dec u_dec (
        .pcfg   (q.pcfg),
        .pinCfg (pinDec)
    );

    apcc_tad_gen #(
        .RC_CYCLES (RC_CYCLES)
    ) u_tad (
        .clock   (clock),
        .rst_n   (rst_n),
        .clkSel  (q.clkSel),
        .run     (q.conv == APCC_CONV_RUN),
        .tadTick (tadTick)
    );

    // ------------------------------------------------------------
    // bus decode
    // ------------------------------------------------------------
    logic       busReq;
    logic       take;
    logic       aligned;
    logic [7:0] wordIdx;
    logic       wrLow;
    logic [7:0] wd;

    assign busReq  = read || write;
    assign take    = busReq && q.ack;
    assign aligned = (address[1:0] == 2'b00);
    assign wordIdx = address[9:2];
    assign wrLow   = write && take && byteenable[0] && aligned;
    assign wd      = writedata[7:0];

    // ------------------------------------------------------------
    // next state
    // ------------------------------------------------------------
    logic [7:0] rdMux;
    logic [7:0] dirPad;
    logic [7:0] latchPad;
    logic [2:0] newChan;
    logic       startReq;
    logic       lastTad;

    always_comb begin
        d        = q;
        rdMux    = 8'h00;
        dirPad   = {3'b000, q.pinDir};
        latchPad = {3'b000, q.portLatch};
        newChan  = wd[`APCC_CTRL_CHAN_LSB +: 3];
        startReq = 1'b0;
        lastTad  = (q.tadCnt == 4'(TAD_PER_CONV - 1));

        // first request cycle answers with wait, second completes
        d.ack = busReq && !q.ack;

        if (aligned) begin
            case (wordIdx)
                `APCC_IDX_PORT_CFG: begin
                    rdMux[`APCC_CFG_JUSTIFY_BIT] = q.justify;
                    rdMux[`APCC_CFG_PCFG_LSB +: 4] = q.pcfg;
                end
                `APCC_IDX_CONV_CTRL: begin
                    rdMux[`APCC_CTRL_CLKSEL_LSB +: 2] = q.clkSel;
                    rdMux[`APCC_CTRL_CHAN_LSB +: 3] = q.chan;
                    rdMux[`APCC_CTRL_GO_BIT] =
                        (q.conv == APCC_CONV_RUN);
                    rdMux[`APCC_CTRL_ENABLE_BIT] = q.enable;
                end
                `APCC_IDX_RES_HIGH: begin
                    if (q.justify) begin
                        rdMux = {6'h00, q.result[9:8]};
                    end else begin
                        rdMux = q.result[9:2];
                    end
                end
                `APCC_IDX_RES_LOW: begin
                    if (q.justify) begin
                        rdMux = q.result[7:0];
                    end else begin
                        rdMux = {q.result[1:0], 6'h00};
                    end
                end
                `APCC_IDX_PORT_DATA: begin
                    // analog pins read low, decode taken live
                    rdMux = {3'b000, pinIn & ~pinDec.analogMask};
                end
                `APCC_IDX_PIN_DIR: begin
                    rdMux = {3'b000, q.pinDir};
                end
                default: begin
                    rdMux = 8'h00;
                end
            endcase
        end
        if (read && !q.ack) begin
            d.rdata = rdMux;
        end

        if (wrLow) begin
            case (wordIdx)
                `APCC_IDX_PORT_CFG: begin
                    d.justify = wd[`APCC_CFG_JUSTIFY_BIT];
                    d.pcfg    = wd[`APCC_CFG_PCFG_LSB +: 4];
                end
                `APCC_IDX_CONV_CTRL: begin
                    d.enable = wd[`APCC_CTRL_ENABLE_BIT];
                    // source and channel frozen while converting
                    if (q.conv == APCC_CONV_IDLE) begin
                        d.clkSel = apcc_clk_sel_t'(
                            wd[`APCC_CTRL_CLKSEL_LSB +: 2]);
                        d.chan   = newChan;
                        startReq = wd[`APCC_CTRL_GO_BIT] &&
                                   wd[`APCC_CTRL_ENABLE_BIT];
                    end
                end
                `APCC_IDX_PORT_DATA: begin
                    d.portLatch = wd[4:0];
                end
                `APCC_IDX_PIN_DIR: begin
                    d.pinDir = wd[4:0];
                end
                default: begin
                end
            endcase
        end

        case (q.conv)
            APCC_CONV_IDLE: begin
                if (startReq) begin
                    d.conv   = APCC_CONV_RUN;
                    d.tadCnt = 4'h0;
                    // pin driven as output converts its own level
                    if (newChan < 3'd5 && !dirPad[newChan]) begin
                        d.sample = {10{latchPad[newChan]}};
                    end else begin
                        d.sample = sampleCode;
                    end
                end
            end
            APCC_CONV_RUN: begin
                if (!d.enable) begin
                    d.conv = APCC_CONV_IDLE;
                end else if (tadTick) begin
                    if (lastTad) begin
                        d.result = q.sample;
                        d.conv   = APCC_CONV_IDLE;
                    end else begin
                        d.tadCnt = q.tadCnt + 4'h1;
                    end
                end
            end
            default: begin
                d.conv = APCC_CONV_IDLE;
            end
        endcase

        // registered copy for the pin side, one cycle behind
        d.pinCfg = pinDec;

        if (!rst_n) begin
            d         = '0;
            d.justify = 1'(`APCC_PORT_CFG_RST >>
                           `APCC_CFG_JUSTIFY_BIT);
            d.pcfg    = 4'(`APCC_PORT_CFG_RST);
            d.pinDir  = `APCC_PIN_DIR_RST;
            d.pinCfg  = '{analogMask: 5'h1f, vrefPosPin: 1'b0,
                          vrefNegPin: 1'b0};
        end
    end

    always_ff @(posedge clock) begin
        q <= d;
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    assign readdata    = {24'h000000, q.rdata};
    assign waitrequest = busReq && !q.ack;
    assign portOut     = q.portLatch;
    assign portOe_n    = q.pinDir;
    assign pinCfg      = q.pinCfg;
    assign chanSel     = q.chan;
    assign converting  = (q.conv == APCC_CONV_RUN);

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    logic [15:0] convCycles;
    logic [15:0] minCycles;
    logic        doneNow;
    logic        rdDone;

    assign doneNow = (q.conv == APCC_CONV_RUN) && tadTick && lastTad &&
                     q.enable;
    assign rdDone  = read && !waitrequest && aligned;

    always_comb begin
        case (q.clkSel)
            APCC_CLK_OSC2:  minCycles = 16'(TAD_PER_CONV * 2);
            APCC_CLK_OSC8:  minCycles = 16'(TAD_PER_CONV * 8);
            APCC_CLK_OSC32: minCycles = 16'(TAD_PER_CONV * 32);
            default:        minCycles = 16'(TAD_PER_CONV * RC_CYCLES);
        endcase
    end

    always_ff @(posedge clock) begin
        if (!rst_n || q.conv == APCC_CONV_IDLE) begin
            convCycles <= 16'h0000;
        end else begin
            convCycles <= convCycles + 16'h0001;
        end
    end

    default clocking cb @(posedge clock); endclocking
    default disable iff (!rst_n);

    sequence s_ctrl_go;
        wrLow && wordIdx == `APCC_IDX_CONV_CTRL &&
        wd[`APCC_CTRL_GO_BIT] && wd[`APCC_CTRL_ENABLE_BIT] &&
        q.conv == APCC_CONV_IDLE;
    endsequence

    AST_RES_RIGHT: assert property (
        rdDone && wordIdx == `APCC_IDX_RES_HIGH && q.justify
        |-> readdata[7:0] == {6'h00, q.result[9:8]})
        else $error("right justified high byte wrong");
    AST_RES_LEFT: assert property (
        rdDone && wordIdx == `APCC_IDX_RES_LOW && !q.justify
        |-> readdata[7:0] == {q.result[1:0], 6'h00})
        else $error("left justified low byte wrong");
    AST_CFG_UNUSED: assert property (
        rdDone && wordIdx == `APCC_IDX_PORT_CFG
        |-> readdata[6:4] == 3'b000 && readdata[3:0] == q.pcfg)
        else $error("port config read wrong");
    AST_PCFG_DIGITAL: assert property (
        q.pcfg[3:1] == 3'b011 |=> pinCfg.analogMask == 5'h00)
        else $error("code 011x left an analog pin");
    AST_PCFG_REFS: assert property (
        q.pcfg == 4'h8 |=> pinCfg.analogMask == 5'h1f &&
        pinCfg.vrefPosPin && pinCfg.vrefNegPin)
        else $error("code 1000 references wrong");
    AST_PORT_ANALOG: assert property (
        read && wordIdx == `APCC_IDX_PORT_DATA && aligned && !q.ack
        |=> (q.rdata[4:0] & $past(pinDec.analogMask)) == 5'h00)
        else $error("analog pin read non-zero");
    AST_CONV_LEN: assert property (
        doneNow |-> convCycles + 16'h0001 >= minCycles)
        else $error("conversion shorter than twelve periods");
    AST_OUT_LEVEL: assert property (
        s_ctrl_go ##0 (newChan < 3'd5 && !dirPad[newChan])
        |=> q.sample == {10{$past(latchPad[newChan])}})
        else $error("output pin level not converted");
    AST_GO_STARTS: assert property (
        s_ctrl_go |=> converting &&
        ($past(newChan < 3'd5 && !dirPad[newChan]) ||
         q.sample == $past(sampleCode)))
        else $error("conversion did not start");
    AST_RESET_CFG: assert property (
        $rose(rst_n) |-> !q.justify && q.pcfg == 4'h0 &&
        pinCfg.analogMask == 5'h1f)
        else $error("config not cleared at reset");

endmodule

// [testbench/apcc_pin_model.sv]
module apcc_pin_model (
    // pins as the device drives them
    input  wire logic [4:0] portOut,
    input  wire logic [4:0] portOe_n,
    // what the device sees back
    output logic      [4:0] pinIn,
    output logic      [9:0] sampleCode,
    // outside levels chosen by the bench
    input  wire logic [4:0] extLevel,
    input  wire logic [9:0] anaLevel
);
    timeunit 1ns;
    timeprecision 100ps;

    // ------------------------------------------------------------
    // pin resolution
    // ------------------------------------------------------------
    // a driven pin reads back its own level, not the outside one
    assign pinIn      = (extLevel & portOe_n) |
                        (portOut & ~portOe_n);
    assign sampleCode = anaLevel;
endmodule

// [testbench/apcc_top_test.sv]
module apcc_top_test
    import apcc_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;

    // 64 clocks of 25 ns keep the RC period at the 1.6 us floor
    localparam int RCC = 64;

    logic          clock = 1'b0;
    logic          rst_n;
    logic [9:0]    address;
    logic          read;
    logic          write;
    logic [31:0]   writedata;
    logic [3:0]    byteenable;
    logic [31:0]   readdata;
    logic          waitrequest;
    logic [4:0]    pinIn;
    logic [9:0]    sampleCode;
    logic [4:0]    portOut;
    logic [4:0]    portOe_n;
    apcc_pin_cfg_t pinCfg;
    logic [2:0]    chanSel;
    logic          converting;
    logic [4:0]    extLevel;
    logic [9:0]    anaLevel;
    int            miscompares;
    int            checks;

    apcc_top #(.RC_CYCLES(RCC)) uut (
        .clock(clock), .rst_n(rst_n), .address(address), .read(read),
        .write(write), .writedata(writedata), .byteenable(byteenable),
        .readdata(readdata), .waitrequest(waitrequest), .pinIn(pinIn),
        .sampleCode(sampleCode), .portOut(portOut), .portOe_n(portOe_n),
        .pinCfg(pinCfg), .chanSel(chanSel), .converting(converting)
    );

    apcc_pin_model pins (
        .portOut(portOut), .portOe_n(portOe_n), .pinIn(pinIn),
        .sampleCode(sampleCode), .extLevel(extLevel), .anaLevel(anaLevel)
    );

    always #12.5 clock = ~clock;

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    function automatic logic [31:0] lfsr(input logic [31:0] x);
        return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
    endfunction

    // expected {analog mask, vref+ on pin, vref- on pin}
    function automatic logic [6:0] exp_cfg(input logic [3:0] c);
        logic [4:0] m;
        logic       p;
        logic       n;
        case (c)
            4'h4, 4'h5: m = 5'h0b;
            4'h6, 4'h7: m = 5'h00;
            4'hd:       m = 5'h0f;
            4'he:       m = 5'h01;
            4'hf:       m = 5'h0d;
            default:    m = 5'h1f;
        endcase
        p = c inside {4'h1, 4'h3, 4'h5, 4'h8, 4'ha, 4'hb, 4'hc, 4'hd, 4'hf};
        n = c inside {4'h8, 4'hb, 4'hc, 4'hd, 4'hf};
        return {m, p, n};
    endfunction

    task automatic chk(input string nm, input logic [31:0] e,
                       input logic [31:0] g);
        checks++;
        if (g !== e) begin
            miscompares++;
            $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
        end
    endtask

    // ------------------------------------------------------------
    // avalon master
    // ------------------------------------------------------------
    task automatic wr(input logic [7:0] idx, input logic [7:0] v);
        @(posedge clock);
        address    <= {idx, 2'b00};
        writedata  <= {24'h0, v};
        byteenable <= 4'h1;
        write      <= 1'b1;
        @(posedge clock);
        while (waitrequest !== 1'b0) @(posedge clock);
        write <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] idx, output logic [31:0] v);
        @(posedge clock);
        address <= {idx, 2'b00};
        read    <= 1'b1;
        @(posedge clock);
        while (waitrequest !== 1'b0) @(posedge clock);
        v = readdata;
        read <= 1'b0;
    endtask

    task automatic end_sim();
        $display("checks %0d miscompares %0d", checks, miscompares);
        if (miscompares == 0 && checks > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    // ------------------------------------------------------------
    // sequence
    // ------------------------------------------------------------
    initial begin
        logic [31:0] rnd;
        logic [31:0] d;
        logic [6:0]  e;
        logic [9:0]  exp;
        logic [9:0]  expQ[$];
        logic [3:0]  pc;
        logic [2:0]  ch;
        int          n;
        int          dv;
        rst_n       = 1'b0;
        address     = '0;
        read        = 1'b0;
        write       = 1'b0;
        writedata   = '0;
        byteenable  = '0;
        extLevel    = '0;
        anaLevel    = '0;
        rnd         = 32'h3169;
        miscompares = 0;
        checks      = 0;
        repeat (2) @(posedge clock);
        rst_n <= 1'b1;
        @(posedge clock);
        chk("pinCfg reset", 32'h7c, 32'(pinCfg));
        rd(8'h9f, d);
        chk("config reset", 32'h0, d);
        rd(8'h85, d);
        chk("direction reset", 32'h1f, d);
        rd(8'h40, d);
        chk("unmapped read", 32'h0, d);
        wr(8'h9f, 8'hff);
        rd(8'h9f, d);
        chk("config bits", 32'h8f, d);
        for (int i = 0; i < 16; i++) begin
            rnd = lfsr(rnd);
            extLevel <= rnd[4:0];
            wr(8'h9f, {4'h0, 4'(i)});
            repeat (2) @(posedge clock);
            e = exp_cfg(4'(i));
            chk("pinCfg decode", 32'(e), 32'(pinCfg));
            rd(8'h05, d);
            chk("port data", 32'(rnd[4:0] & ~e[6:2]), d);
        end
        // pin one driven high, so channel one converts all ones
        wr(8'h85, 8'h1d);
        wr(8'h05, 8'h02);
        @(posedge clock);
        chk("portOe_n", 32'h1d, 32'(portOe_n));
        chk("portOut", 32'h02, 32'(portOut));
        // a 40 MHz oscillator is past every divider limit, so the
        // divider runs check timing only; RC keeps the period floor
        for (int i = 0; i < 4; i++) begin
            ch = (i == 1) ? 3'd1 : (i == 2) ? 3'd6 : 3'd0;
            pc = (i == 3) ? 4'h6 : 4'h0;
            rnd = lfsr(rnd);
            anaLevel <= rnd[9:0];
            expQ.push_back((ch == 3'd1) ? 10'h3ff : rnd[9:0]);
            dv = (i == 3) ? RCC : (2 << (2 * i));
            wr(8'h9f, {4'h0, pc});
            wr(8'h1f, {2'(i), ch, 3'b101});
            n = 0;
            do begin
                @(posedge clock);
                if (converting === 1'b1) n++;
            end while (converting === 1'b1 || n == 0);
            chk("conversion length", 32'h1,
                32'(n >= 12 * dv && n <= 12 * dv + 1));
            rd(8'h1f, d);
            chk("control readback", 32'({2'(i), ch, 3'b001}), d);
            chk("chanSel", 32'(ch), 32'(chanSel));
            exp = expQ.pop_front();
            wr(8'h9f, {4'h8, pc});
            rd(8'h1e, d);
            chk("result high right", 32'(exp[9:8]), d);
            rd(8'h9e, d);
            chk("result low right", 32'(exp[7:0]), d);
            wr(8'h9f, {4'h0, pc});
            rd(8'h1e, d);
            chk("result high left", 32'(exp[9:2]), d);
            rd(8'h9e, d);
            chk("result low left", 32'({exp[1:0], 6'h0}), d);
        end
        // second reset mid-run: configuration returns to power-up
        rst_n <= 1'b0;
        repeat (2) @(posedge clock);
        rst_n <= 1'b1;
        @(posedge clock);
        chk("pinCfg after reset", 32'h7c, 32'(pinCfg));
        rd(8'h9f, d);
        chk("config after reset", 32'h0, d);
        end_sim();
    end

    // hang guard, well beyond the longest expected run
    initial begin
        repeat (20000) @(posedge clock);
        miscompares++;
        end_sim();
    end
endmodule
